// file: hdl/rdag_defs.vh
// register map, field positions, reset values and codes of the gain limit block
`ifndef RDAG_DEFS_VH
`define RDAG_DEFS_VH

// byte addresses
`define RDAG_CGS1_OFS 8'h08
`define RDAG_CTRL_OFS 8'h20
`define RDAG_STAT_OFS 8'h24

// reset values
`define RDAG_CGS1_RST 32'h00011b01
`define RDAG_SCHEME_RST 2'h0
`define RDAG_SHORT_DIS_RST 1'b0
`define RDAG_DISABLE_RST 1'b0
`define RDAG_INIT_GAIN_RST 4'h0
`define RDAG_RESTRICT_RST 1'b1
`define RDAG_UPPER_RST 4'h1
`define RDAG_LOWER_RST 4'hb
`define RDAG_VSEL_RST 3'h1
`define RDAG_GAIN_RST 4'h1
`define RDAG_RES_RST 5'h0c

// control_gain_select_1 fields
`define RDAG_SHORT_DIS_BIT 28
`define RDAG_DISABLE_BIT 24
`define RDAG_INIT_GAIN_HI 23
`define RDAG_INIT_GAIN_LO 20
`define RDAG_RESTRICT_BIT 16
`define RDAG_UPPER_HI 15
`define RDAG_UPPER_LO 12
`define RDAG_LOWER_HI 11
`define RDAG_LOWER_LO 8
`define RDAG_VSEL_HI 2
`define RDAG_VSEL_LO 0

// own control register fields
`define RDAG_KICK_BIT 0
`define RDAG_SCHEME_HI 5
`define RDAG_SCHEME_LO 4

// status register fields
`define RDAG_ST_GAIN_HI 3
`define RDAG_ST_GAIN_LO 0
`define RDAG_ST_ACTIVE_BIT 4
`define RDAG_ST_FREE_BIT 5
`define RDAG_ST_RES_HI 10
`define RDAG_ST_RES_LO 6
`define RDAG_ST_CERR_BIT 16

// gain control schemes
`define RDAG_SCH_12 2'h0
`define RDAG_SCH_7 2'h1
`define RDAG_SCH_2 2'h2

// gain codes: 0 is x128, 1 is x64 ... 11 is x0.0625
`define RDAG_GAIN_X128 4'h0
`define RDAG_GAIN_MIN_CODE 4'h1
`define RDAG_GAIN_MAX_CODE 4'hb
`define RDAG_STEP_12 5'h01
`define RDAG_STEP_7 5'h02

`endif

// file: hdl/rdag_code_chk.v
// legality check of one gain limit code
`timescale 1ns/1ns
`include "rdag_defs.vh"

module rdag_code_chk
(
   input wire [3:0] code,
   output wire legal
);

   // codes 1..11 are usable, 0 and 12..15 are not
   assign legal = (code >= `RDAG_GAIN_MIN_CODE) && (code <= `RDAG_GAIN_MAX_CODE);

endmodule

// file: hdl/rdag_res_map.v
// velocity select to conversion resolution decode
`timescale 1ns/1ns
`include "rdag_defs.vh"

module rdag_res_map
(
   input wire [2:0] vsel,
   output reg [4:0] res_bits
);

   // resolution in bits for each maximum velocity choice
   always @*
   begin
      case (vsel)
         3'h0: res_bits = 5'h0d;
         3'h1: res_bits = 5'h0c;
         3'h2: res_bits = 5'h0b;
         3'h3: res_bits = 5'h0a;
         3'h4: res_bits = 5'h10;
         3'h5: res_bits = 5'h0e;
         default: res_bits = 5'h0c;
      endcase
   end

endmodule

// file: hdl/rdag_top.v
// gain limit configuration and automatic gain stepping of the tracking loop
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "rdag_defs.vh"

module rdag_top
(
   input wire ref_clk,
   input wire rst,
   input wire [7:0] addr,
   input wire [31:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   input wire signal_error_recovered,
   input wire gain_step_up,
   input wire gain_step_down,
   output reg [31:0] rd_data_q,
   output reg [3:0] velocity_loop_gain_q,
   output reg gain_control_active_state_q,
   output reg free_running_q,
   output reg integral_reset_trigger_q,
   output reg [2:0] max_velocity_select_q,
   output reg [4:0] resolution_q,
   output reg short_agc_disable_q,
   output reg [3:0] short_init_gain_q
);

   // gain control states
   localparam ST_RUN = 2'd0;
   localparam ST_OFF = 2'd1;
   localparam ST_FREE = 2'd2;

   reg gain_control_disable_q;
   reg high_gain_restrict_q;
   reg [3:0] upper_gain_limit_q;
   reg [3:0] lower_gain_limit_q;
   reg [1:0] agc_scheme_q;
   reg code_error_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] gain_d;
   reg [4:0] cand;
   wire [4:0] step;
   wire wr_cgs1;
   wire wr_ctrl;
   wire wr_stat;
   wire kick;
   wire disable_change;
   wire boost;
   wire upper_ok;
   wire lower_ok;
   wire [4:0] res_bits;
   wire [3:0] new_upper;
   wire [3:0] new_lower;

   // address decode, full word writes only
   assign wr_cgs1 = wr_en && (addr == `RDAG_CGS1_OFS);
   assign wr_ctrl = wr_en && (addr == `RDAG_CTRL_OFS);
   assign wr_stat = wr_en && (addr == `RDAG_STAT_OFS);
   assign new_upper = wr_data[`RDAG_UPPER_HI:`RDAG_UPPER_LO];
   assign new_lower = wr_data[`RDAG_LOWER_HI:`RDAG_LOWER_LO];

   // integral reset request written by software
   assign kick = wr_ctrl && wr_data[`RDAG_KICK_BIT];

   // a write that flips the disable bit
   assign disable_change = wr_cgs1 && (wr_data[`RDAG_DISABLE_BIT] != gain_control_disable_q);

   // events that pull the gain high
   assign boost = kick || signal_error_recovered;

   // legality of the incoming limit codes
   rdag_code_chk u_upper_chk
   (
      .code(new_upper),
      .legal(upper_ok)
   );

   rdag_code_chk u_lower_chk
   (
      .code(new_lower),
      .legal(lower_ok)
   );

   // resolution of the current velocity choice
   rdag_res_map u_res_map
   (
      .vsel(max_velocity_select_q),
      .res_bits(res_bits)
   );

   // configuration fields of control_gain_select_1
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         short_agc_disable_q <= `RDAG_SHORT_DIS_RST;
         gain_control_disable_q <= `RDAG_DISABLE_RST;
         short_init_gain_q <= `RDAG_INIT_GAIN_RST;
         high_gain_restrict_q <= `RDAG_RESTRICT_RST;
         upper_gain_limit_q <= `RDAG_UPPER_RST;
         lower_gain_limit_q <= `RDAG_LOWER_RST;
         max_velocity_select_q <= `RDAG_VSEL_RST;
      end
      else if (wr_cgs1)
      begin
         short_agc_disable_q <= wr_data[`RDAG_SHORT_DIS_BIT];
         gain_control_disable_q <= wr_data[`RDAG_DISABLE_BIT];
         short_init_gain_q <= wr_data[`RDAG_INIT_GAIN_HI:`RDAG_INIT_GAIN_LO];
         high_gain_restrict_q <= wr_data[`RDAG_RESTRICT_BIT];
         max_velocity_select_q <= wr_data[`RDAG_VSEL_HI:`RDAG_VSEL_LO];
         // illegal limit codes are not taken, the old limit stays
         if (upper_ok)
         begin
            upper_gain_limit_q <= new_upper;
         end
         if (lower_ok)
         begin
            lower_gain_limit_q <= new_lower;
         end
      end
   end

   // scheme select in the own control register
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         agc_scheme_q <= `RDAG_SCHEME_RST;
      end
      else if (wr_ctrl)
      begin
         agc_scheme_q <= wr_data[`RDAG_SCHEME_HI:`RDAG_SCHEME_LO];
      end
   end

   // sticky flag for a refused limit code, a new error wins over the clear
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         code_error_q <= 1'b0;
      end
      else if (wr_cgs1 && !(upper_ok && lower_ok))
      begin
         code_error_q <= 1'b1;
      end
      else if (wr_stat && wr_data[`RDAG_ST_CERR_BIT])
      begin
         code_error_q <= 1'b0;
      end
   end

   // state sequence: a disable change drops into free running until the trigger
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN, ST_OFF:
         begin
            if (disable_change)
            begin
               state_d = ST_FREE;
            end
         end
         ST_FREE:
         begin
            if (kick && gain_control_disable_q)
            begin
               state_d = ST_OFF;
            end
            else if (kick)
            begin
               state_d = ST_RUN;
            end
         end
         default:
         begin
            state_d = ST_FREE;
         end
      endcase
   end

   // state register and its visible flags
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_RUN;
         gain_control_active_state_q <= 1'b1;
         free_running_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         gain_control_active_state_q <= (state_d == ST_RUN);
         free_running_q <= (state_d == ST_FREE);
      end
   end

   // level spacing of the selected scheme
   assign step = (agc_scheme_q == `RDAG_SCH_7) ? `RDAG_STEP_7 : `RDAG_STEP_12;

   // next gain: boost first, then one step within the limits
   always @*
   begin
      gain_d = velocity_loop_gain_q;
      cand = {1'b0, velocity_loop_gain_q};
      if (state_d != ST_RUN)
      begin
         gain_d = velocity_loop_gain_q;
      end
      else if (boost && !high_gain_restrict_q)
      begin
         if (agc_scheme_q == `RDAG_SCH_2)
         begin
            gain_d = upper_gain_limit_q;
         end
         else
         begin
            gain_d = `RDAG_GAIN_X128;
         end
      end
      else if (boost)
      begin
         gain_d = velocity_loop_gain_q;
      end
      else if (agc_scheme_q == `RDAG_SCH_2)
      begin
         // two levels: the limits themselves
         if (gain_step_up)
         begin
            gain_d = upper_gain_limit_q;
         end
         else if (gain_step_down)
         begin
            gain_d = lower_gain_limit_q;
         end
      end
      else if (gain_step_up)
      begin
         // a smaller code is a larger gain
         cand = {1'b0, velocity_loop_gain_q} - step;
         if (cand[4] || (cand < {1'b0, upper_gain_limit_q}))
         begin
            gain_d = upper_gain_limit_q;
         end
         else
         begin
            gain_d = cand[3:0];
         end
      end
      else if (gain_step_down)
      begin
         cand = {1'b0, velocity_loop_gain_q} + step;
         if (cand > {1'b0, lower_gain_limit_q})
         begin
            gain_d = lower_gain_limit_q;
         end
         // from x128 a step down lands on the upper limit, a level of every scheme
         else if ((cand < {1'b0, upper_gain_limit_q}) || (velocity_loop_gain_q == `RDAG_GAIN_X128))
         begin
            gain_d = upper_gain_limit_q;
         end
         else
         begin
            gain_d = cand[3:0];
         end
      end
   end

   // gain from the upper limit of the reset value, one cycle integral reset, registered resolution
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         velocity_loop_gain_q <= `RDAG_GAIN_RST;
         integral_reset_trigger_q <= 1'b0;
         resolution_q <= `RDAG_RES_RST;
      end
      else
      begin
         velocity_loop_gain_q <= gain_d;
         integral_reset_trigger_q <= kick;
         resolution_q <= res_bits;
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_data_q <= 32'h00000000;
      end
      else
      begin
         rd_data_q <= 32'h00000000;
         if (rd_en)
         begin
            case (addr)
               `RDAG_CGS1_OFS:
               begin
                  // reserved bits read their reset value of zero
                  rd_data_q[`RDAG_SHORT_DIS_BIT] <= short_agc_disable_q;
                  rd_data_q[`RDAG_DISABLE_BIT] <= gain_control_disable_q;
                  rd_data_q[`RDAG_INIT_GAIN_HI:`RDAG_INIT_GAIN_LO] <= short_init_gain_q;
                  rd_data_q[`RDAG_RESTRICT_BIT] <= high_gain_restrict_q;
                  rd_data_q[`RDAG_UPPER_HI:`RDAG_UPPER_LO] <= upper_gain_limit_q;
                  rd_data_q[`RDAG_LOWER_HI:`RDAG_LOWER_LO] <= lower_gain_limit_q;
                  rd_data_q[`RDAG_VSEL_HI:`RDAG_VSEL_LO] <= max_velocity_select_q;
               end
               `RDAG_CTRL_OFS:
               begin
                  rd_data_q[`RDAG_SCHEME_HI:`RDAG_SCHEME_LO] <= agc_scheme_q;
               end
               `RDAG_STAT_OFS:
               begin
                  rd_data_q[`RDAG_ST_GAIN_HI:`RDAG_ST_GAIN_LO] <= velocity_loop_gain_q;
                  rd_data_q[`RDAG_ST_ACTIVE_BIT] <= gain_control_active_state_q;
                  rd_data_q[`RDAG_ST_FREE_BIT] <= free_running_q;
                  rd_data_q[`RDAG_ST_RES_HI:`RDAG_ST_RES_LO] <= resolution_q;
                  rd_data_q[`RDAG_ST_CERR_BIT] <= code_error_q;
               end
               default:
               begin
                  rd_data_q <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule

// file: tb/rdag_asserts.sv
// concurrent checks on the ports of the gain limit block
`timescale 1ns/1ns
module rdag_asserts
(
   input logic ref_clk,
   input logic rst,
   input logic [7:0] addr,
   input logic [31:0] wr_data,
   input logic wr_en,
   input logic rd_en,
   input logic signal_error_recovered,
   input logic gain_step_up,
   input logic gain_step_down,
   input logic [31:0] rd_data_q,
   input logic [3:0] velocity_loop_gain_q,
   input logic gain_control_active_state_q,
   input logic free_running_q,
   input logic integral_reset_trigger_q,
   input logic [2:0] max_velocity_select_q,
   input logic [4:0] resolution_q
);
   logic rs_q, dis_q, w08, kick, run;
   logic [3:0] up_q, lo_q, eu, ed;
   logic [1:0] sch_q;
   logic [4:0] g, st;
   logic [2:0] wv;
   logic [4:0] res_t [8] = '{5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h10, 5'h0e, 5'h0c, 5'h0c};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // decoded requests and the expected gain after one step
   assign w08 = wr_en && addr == 8'h08;
   assign kick = wr_en && addr == 8'h20 && wr_data[0];
   assign run = gain_control_active_state_q && !free_running_q;
   assign g = {1'b0, velocity_loop_gain_q};
   assign st = (sch_q == 2'h1) ? 5'h02 : 5'h01;
   assign wv = wr_data[2:0];
   assign eu = (g >= up_q + st) ? g[3:0] - st[3:0] : up_q;
   assign ed = (g == 5'h0) ? up_q : (g + st <= lo_q) ? g[3:0] + st[3:0] : lo_q;
   // shadow of disable, restrict, limits and scheme; illegal limit codes are not taken
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         {dis_q, rs_q, up_q, lo_q, sch_q} <= 12'h46c;
      else if (w08)
      begin
         dis_q <= wr_data[24];
         rs_q <= wr_data[16];
         if (wr_data[15:12] != 4'h0 && wr_data[15:12] < 4'hc)
            up_q <= wr_data[15:12];
         if (wr_data[11:8] != 4'h0 && wr_data[11:8] < 4'hc)
            lo_q <= wr_data[11:8];
      end
      else if (wr_en && addr == 8'h20)
         sch_q <= wr_data[5:4];
   end
   property p_boost;
      signal_error_recovered && run && !wr_en && !rs_q |=> velocity_loop_gain_q == (sch_q == 2'h2 ? up_q : 4'h0);
   endproperty
   a_boost: assert property (p_boost) else $error("gain not raised on recovery");
   property p_hold;
      signal_error_recovered && run && !wr_en && rs_q && !gain_step_up && !gain_step_down |=> $stable(velocity_loop_gain_q);
   endproperty
   a_hold: assert property (p_hold) else $error("restricted gain moved");
   property p_up;
      gain_step_up && !signal_error_recovered && run && !wr_en && sch_q != 2'h2 && g >= up_q && g <= lo_q
      |=> velocity_loop_gain_q == $past(eu);
   endproperty
   a_up: assert property (p_up) else $error("wrong gain after step up");
   property p_dn;
      gain_step_down && !gain_step_up && !signal_error_recovered && run && !wr_en && sch_q != 2'h2
      && (g == 5'h0 || (g >= up_q && g <= lo_q)) |=> velocity_loop_gain_q == $past(ed);
   endproperty
   a_dn: assert property (p_dn) else $error("wrong gain after step down");
   property p_vsel;
      w08 |=> max_velocity_select_q == $past(wv);
   endproperty
   a_vsel: assert property (p_vsel) else $error("velocity select not written");
   property p_res;
      resolution_q == res_t[$past(max_velocity_select_q)];
   endproperty
   a_res: assert property (p_res) else $error("wrong resolution");
   property p_rsv;
      rd_en && addr == 8'h08 |=> rd_data_q[7:3] == 5'h0 && rd_data_q[19:17] == 3'h0
      && rd_data_q[27:25] == 3'h0 && rd_data_q[31:29] == 3'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   property p_free;
      w08 && wr_data[24] != dis_q |=> free_running_q && !gain_control_active_state_q;
   endproperty
   a_free: assert property (p_free) else $error("no free run after disable change");
   property p_clr;
      kick && free_running_q |=> !free_running_q;
   endproperty
   a_clr: assert property (p_clr) else $error("free run not ended by trigger");
   property p_kick;
      integral_reset_trigger_q == $past(kick);
   endproperty
   a_kick: assert property (p_kick) else $error("trigger pulse wrong");
   property p_act;
      !free_running_q |-> gain_control_active_state_q == !dis_q;
   endproperty
   a_act: assert property (p_act) else $error("active state not matching disable");
endmodule
bind rdag_top rdag_asserts rdag_asserts_i (.*);

// file: tb/rd_agc_gain_limit_config_tb.sv
// self-checking bench of the gain limit block
`timescale 1ns/1ns
module rd_agc_gain_limit_config_tb;
   logic ref_clk, rst, wr_en, rd_en, signal_error_recovered, gain_step_up, gain_step_down;
   logic [7:0] addr;
   logic [31:0] wr_data, rd_data_q;
   logic [3:0] velocity_loop_gain_q, short_init_gain_q;
   logic gain_control_active_state_q, free_running_q, integral_reset_trigger_q, short_agc_disable_q;
   logic [2:0] max_velocity_select_q;
   logic [4:0] resolution_q;
   logic [4:0] res_t [8] = '{5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h10, 5'h0e, 5'h0c, 5'h0c};
   int failures = 0;
   int samples_checked = 0;
   int up, lo, sch, s, r, g, rs;
   rdag_top rdag_top_i (.*);
   // compare, count and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // one-cycle register write and read; read data are settled on return
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
   endtask
   // one pulse of loop events
   task automatic ev(input logic u, input logic d, input logic e);
      @(posedge ref_clk);
      {gain_step_up, gain_step_down, signal_error_recovered} <= {u, d, e};
      @(posedge ref_clk);
      {gain_step_up, gain_step_down, signal_error_recovered} <= 3'h0;
      #1;
   endtask
   // expected gain code after one loop event
   function automatic int next_gain(input int cur, input bit su, input bit sd, input bit rec, input int rb,
      input int sc, input int hi, input int lw);
      int st;
      st = (sc == 1) ? 2 : 1;
      if (rec)
         return (rb != 0) ? cur : (sc == 2) ? hi : 0;
      if (sc == 2)
         return su ? hi : sd ? lw : cur;
      if (su)
         return (cur - st < hi) ? hi : cur - st;
      if (sd)
         return (cur == 0 || cur + st < hi) ? hi : (cur + st > lw) ? lw : cur + st;
      return cur;
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // clock and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial
   begin
      #200000;
      failures++;
      conclude();
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      {wr_en, rd_en, signal_error_recovered, gain_step_up, gain_step_down} = 5'h0;
      addr = 8'h00;
      wr_data = 32'h0;
      void'($urandom(32'h81fb3ad8));
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd(8'h08);
      chk(rd_data_q, 32'h00011b01, "reset image");
      rd(8'h30);
      chk(rd_data_q, 32'h0, "unmapped read");
      chk(velocity_loop_gain_q, 4'h1, "reset gain");
      for (int v = 0; v < 8; v++)
      begin
         wr(8'h08, 32'h00001b00 | v);
         @(posedge ref_clk);
         #1;
         chk(resolution_q, res_t[v], "resolution");
         chk(max_velocity_select_q, v, "velocity select");
      end
      ev(1'b0, 1'b0, 1'b1);
      chk(velocity_loop_gain_q, 4'h0, "boost");
      ev(1'b0, 1'b1, 1'b0);
      chk(velocity_loop_gain_q, 4'h1, "step down from top");
      wr(8'h20, 32'h1);
      chk({integral_reset_trigger_q, velocity_loop_gain_q}, 5'h10, "trigger boost");
      wr(8'h08, 32'h10511b01);
      chk({short_agc_disable_q, short_init_gain_q}, 5'h15, "short fields");
      ev(1'b0, 1'b1, 1'b0);
      ev(1'b0, 1'b0, 1'b1);
      chk(velocity_loop_gain_q, 4'h1, "restricted boost");
      wr(8'h08, 32'h00010c01);
      rd(8'h08);
      chk(rd_data_q, 32'h00011b01, "illegal limit codes");
      rd(8'h24);
      chk(rd_data_q[16], 1'b1, "code error flag");
      @(posedge ref_clk);
      #1;
      chk(rd_data_q, 32'h0, "read data one cycle only");
      wr(8'h24, 32'h00010000);
      rd(8'h24);
      chk(rd_data_q[16], 1'b0, "code error clear");
      // random limits and loop events under each scheme in turn; odd codes under 7-level, upper gain above lower
      g = 1;
      for (int n = 0; n < 6; n++)
      begin
         sch = n % 3;
         s = (sch == 1) ? 2 : 1;
         up = 1 + s * ($urandom % ((sch == 1) ? 5 : 10));
         lo = up + s * (1 + $urandom % ((11 - up) / s));
         rs = $urandom % 2;
         wr(8'h20, sch << 4);
         rd(8'h20);
         chk(rd_data_q, sch << 4, "scheme readback");
         wr(8'h08, rs << 16 | up << 12 | lo << 8 | 1);
         repeat (40)
         begin
            r = $urandom % 3;
            ev(r == 1, r == 2, r == 0);
            g = next_gain(g, r == 1, r == 2, r == 0, rs, sch, up, lo);
            chk(velocity_loop_gain_q, g, "gain after event");
         end
         ev(1'b0, 1'b1, 1'b0);
         g = next_gain(g, 1'b0, 1'b1, 1'b0, rs, sch, up, lo);
         chk(sch == 2 ? velocity_loop_gain_q == lo : velocity_loop_gain_q >= up && velocity_loop_gain_q <= lo,
            1'b1, "gain range");
      end
      wr(8'h08, 32'h01011b01);
      chk({free_running_q, gain_control_active_state_q}, 2'h2, "disable change");
      wr(8'h20, 32'h1);
      chk({free_running_q, gain_control_active_state_q}, 2'h0, "disabled");
      wr(8'h08, 32'h00011b01);
      wr(8'h20, 32'h1);
      chk({free_running_q, gain_control_active_state_q}, 2'h1, "enabled");
      conclude();
   end
endmodule
